/* File: pkg/ams_pkg.sv */
package ams_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [31:0] CFG_OFFSET    = 32'h0000_0000;
    localparam logic [31:0] DATA_OFFSET   = 32'h0000_0004;
    localparam logic [31:0] STATUS_OFFSET = 32'h0000_0008;

    localparam int CFG_W    = 13;
    localparam int CH_LSB   = 0;
    localparam int ACQ_LSB  = 4;
    localparam int SYNC_BIT = 8;
    localparam int CMD_LSB  = 9;
    localparam int BW_BIT   = 12;
    localparam int HI_LSB   = 8;

    localparam int ST_STANDBY_N = 0;
    localparam int ST_READY_N   = 1;
    localparam int ST_SAMPLING  = 2;
    localparam int ST_SYNC_MODE = 3;
    localparam int ST_FSM_LSB   = 4;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // command codes and channel select
    // ------------------------------------------------------------
    localparam logic [2:0] CMD_STANDBY   = 3'h0;
    localparam logic [2:0] CMD_FULL_CAL  = 3'h1;
    localparam logic [2:0] CMD_AUTO_ZERO = 3'h2;
    localparam logic [2:0] CMD_RESET     = 3'h3;
    localparam logic [2:0] CMD_START     = 3'h4;
    localparam int         SINGLE_BIT    = 3;
    localparam int         COM_BIT       = 8;

    // ------------------------------------------------------------
    // timing, in clk_sys cycles
    // ------------------------------------------------------------
    localparam logic [15:0] ACQ_CYC_00  = 16'h0009;
    localparam logic [15:0] ACQ_CYC_01  = 16'h000F;
    localparam logic [15:0] ACQ_CYC_10  = 16'h002F;
    localparam logic [15:0] ACQ_CYC_11  = 16'h004F;
    localparam logic [15:0] WAKE_CYC    = 16'h0040;
    localparam logic [15:0] CAL_CYC     = 16'h0800;
    localparam logic [15:0] AZ_CYC      = 16'h0040;
    localparam logic [15:0] CONV_CYC    = 16'h0020;
    localparam logic [15:0] CNT_ONE     = 16'h0001;
    localparam logic [15:0] CNT_ZERO    = 16'h0000;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        FSM_STANDBY   = 3'h0,
        FSM_WAKE      = 3'h1,
        FSM_IDLE      = 3'h3,
        FSM_ACQ       = 3'h2,
        FSM_CONV      = 3'h6,
        FSM_WAIT_SYNC = 3'h7,
        FSM_CAL       = 3'h5,
        FSM_AZ        = 3'h4
    } ams_fsm_t;

    typedef struct packed {
        ams_fsm_t          state;
        logic [CFG_W-1:0]  cfg;
        logic [CFG_W-1:0]  data;
        logic [15:0]       cnt;
        logic              ready_n;
        logic              standby_n;
        logic              sampling;
        logic              sync_out;
        logic              sync_meta;
        logic              sync_sync;
        logic              sync_prev;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
    } ams_regs_t;

    // power-up: standby, sync mode, command 000, bus narrow
    localparam logic [CFG_W-1:0] CFG_RESET = 13'h0100;
    localparam logic [CFG_W-1:0] DATA_RESET = 13'h0000;

endpackage

/* File: core/ams_core.sv */
// Implementation choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module ams_core
    import ams_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [12:0] conv_result,
    input  wire logic        sync_in,
    output logic             sync_out,
    output logic             sync_oe,
    output logic             standby_flag_n,
    output logic             ready_n,
    output logic             sampling,
    output logic             converting,
    output logic             calibrating,
    output logic [7:0]       mux_out_pos,
    output logic [8:0]       mux_out_neg
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] acq_cycles(input logic [1:0] sel);
        case (sel)
            2'h0:    acq_cycles = ACQ_CYC_00;
            2'h1:    acq_cycles = ACQ_CYC_01;
            2'h2:    acq_cycles = ACQ_CYC_10;
            default: acq_cycles = ACQ_CYC_11;
        endcase
    endfunction

    function automatic logic [CFG_W-1:0] merge_cfg(input logic [CFG_W-1:0] old,
                                                 input logic [31:0] wd,
                                                 input logic [3:0] strb);
        logic [CFG_W-1:0] v;
        v = old;
        if (strb[0]) begin
            v[HI_LSB-1:0] = wd[HI_LSB-1:0];
        end
        if (strb[1]) begin
            v[CFG_W-1:HI_LSB] = wd[CFG_W-1:HI_LSB];
        end
        merge_cfg = v;
    endfunction

    ams_regs_t r_reg;
    ams_regs_t r_next;

    logic        wr_fire;
    logic        rd_fire;
    logic        wr_cfg;
    logic [CFG_W-1:0] cfg_new;
    logic [2:0]  cmd_new;
    logic        chan_changed;
    logic        sync_mode;
    logic        sync_rise;
    logic        host_read;
    logic        cnt_done;
    logic [2:0]  chan_pos;

    // ------------------------------------------------------------
    // bus handshakes
    // ------------------------------------------------------------
    // address and data taken together so one write needs no holding register
    assign s_axi_awready = s_axi_awvalid & s_axi_wvalid & ~r_reg.bvalid;
    assign s_axi_wready  = s_axi_awready;
    assign s_axi_arready = ~r_reg.rvalid;
    assign wr_fire       = s_axi_awready;
    assign rd_fire       = s_axi_arvalid & s_axi_arready;
    assign wr_cfg        = wr_fire & (s_axi_awaddr == CFG_OFFSET);

    assign s_axi_bvalid = r_reg.bvalid;
    assign s_axi_bresp  = r_reg.bresp;
    assign s_axi_rvalid = r_reg.rvalid;
    assign s_axi_rdata  = r_reg.rdata;
    assign s_axi_rresp  = r_reg.rresp;

    assign cfg_new      = merge_cfg(r_reg.cfg, s_axi_wdata, s_axi_wstrb);
    assign cmd_new      = cfg_new[CMD_LSB +: 3];
    assign chan_changed = cfg_new[CH_LSB +: 4] != r_reg.cfg[CH_LSB +: 4];
    assign sync_mode    = r_reg.cfg[SYNC_BIT];
    assign sync_rise    = r_reg.sync_sync & ~r_reg.sync_prev;
    assign cnt_done     = r_reg.cnt == CNT_ZERO;
    assign host_read    = rd_fire & (s_axi_araddr == DATA_OFFSET) & (r_reg.state == FSM_IDLE)
                          & (r_reg.cfg[CMD_LSB +: 3] == CMD_START);

    // ------------------------------------------------------------
    // pins
    // ------------------------------------------------------------
    assign standby_flag_n = r_reg.standby_n;
    assign ready_n        = r_reg.ready_n;
    assign sampling       = r_reg.sampling;
    assign converting     = r_reg.state == FSM_CONV;
    assign calibrating    = (r_reg.state == FSM_CAL) | (r_reg.state == FSM_AZ);
    assign sync_oe        = ~sync_mode;
    assign sync_out       = r_reg.sync_out;

    // differential: pair index in bits 2:1, bit 0 picks the positive member
    assign chan_pos = r_reg.cfg[SINGLE_BIT] ? r_reg.cfg[CH_LSB +: 3]
                                            : r_reg.cfg[CH_LSB +: 3];
    always_comb begin
        mux_out_pos = 8'h00;
        mux_out_neg = 9'h000;
        mux_out_pos[chan_pos] = 1'b1;
        if (r_reg.cfg[SINGLE_BIT]) begin
            mux_out_neg[COM_BIT] = 1'b1;
        end else begin
            mux_out_neg[{chan_pos[2:1], ~chan_pos[0]}] = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        r_next = r_reg;
        r_next.sync_meta = sync_in;
        r_next.sync_sync = r_reg.sync_meta;
        r_next.sync_prev = r_reg.sync_sync;
        if (!cnt_done) begin
            r_next.cnt = r_reg.cnt - CNT_ONE;
        end

        // timed phases
        case (r_reg.state)
            FSM_WAKE: begin
                if (cnt_done) begin
                    r_next.state    = FSM_IDLE;
                    r_next.ready_n  = 1'b0;
                    r_next.sampling = 1'b1;
                end
            end
            FSM_ACQ: begin
                if (cnt_done) begin
                    r_next.state    = FSM_CONV;
                    r_next.cnt      = CONV_CYC - CNT_ONE;
                    r_next.sampling = 1'b0;
                    r_next.sync_out = 1'b1;
                end
            end
            FSM_CONV: begin
                if (cnt_done) begin
                    r_next.state    = FSM_IDLE;
                    r_next.data     = conv_result;
                    r_next.ready_n  = 1'b0;
                    r_next.sampling = 1'b1;
                    r_next.sync_out = 1'b0;
                end
            end
            FSM_CAL, FSM_AZ: begin
                if (cnt_done) begin
                    r_next.state    = FSM_IDLE;
                    r_next.ready_n  = 1'b0;
                    r_next.sampling = 1'b1;
                end
            end
            default: begin
            end
        endcase

        // host read of the result arms the next sample
        if (host_read) begin
            r_next.ready_n = 1'b1;
            if (sync_mode) begin
                r_next.state = FSM_WAIT_SYNC;
            end else begin
                r_next.state = FSM_ACQ;
                r_next.cnt   = acq_cycles(r_reg.cfg[ACQ_LSB +: 2]) - CNT_ONE;
            end
        end

        // in synchronous mode a sync rising edge starts conversion from FSM_IDLE or FSM_WAIT_SYNC; a running FSM_ACQ still ends in FSM_CONV
        if (sync_mode && sync_rise && (r_reg.cfg[CMD_LSB +: 3] == CMD_START)
            && ((r_reg.state == FSM_IDLE) || (r_reg.state == FSM_WAIT_SYNC))) begin
            r_next.state    = FSM_CONV;
            r_next.cnt      = CONV_CYC - CNT_ONE;
            r_next.sync_out = 1'b1;
            r_next.ready_n  = 1'b1;
            r_next.sampling = 1'b0;
        end

        // configuration write wins over everything above
        if (wr_cfg) begin
            r_next.cfg = cfg_new;
            if (cmd_new == CMD_STANDBY) begin
                r_next.state     = FSM_STANDBY;
                r_next.standby_n = 1'b0;
                r_next.ready_n   = 1'b1;
                r_next.sampling  = 1'b0;
                r_next.sync_out  = 1'b0;
            end else if (r_reg.state == FSM_STANDBY) begin
                r_next.state     = FSM_WAKE;
                r_next.standby_n = 1'b1;
                r_next.cnt       = WAKE_CYC - CNT_ONE;
            end else if ((r_reg.state == FSM_IDLE) || (r_reg.state == FSM_WAIT_SYNC)) begin
                case (cmd_new)
                    CMD_FULL_CAL: begin
                        r_next.state    = FSM_CAL;
                        r_next.cnt      = CAL_CYC - CNT_ONE;
                        r_next.ready_n  = 1'b1;
                        r_next.sampling = 1'b0;
                    end
                    CMD_AUTO_ZERO: begin
                        r_next.state    = FSM_AZ;
                        r_next.cnt      = AZ_CYC - CNT_ONE;
                        r_next.ready_n  = 1'b1;
                        r_next.sampling = 1'b0;
                    end
                    CMD_RESET: begin
                        r_next.state   = FSM_IDLE;
                        r_next.ready_n = 1'b0;
                    end
                    default: begin
                        if (chan_changed) begin
                            r_next.sampling = 1'b1;
                        end
                    end
                endcase
            end
        end

        // write response
        if (wr_fire) begin
            r_next.bvalid = 1'b1;
            r_next.bresp  = wr_cfg ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            r_next.bvalid = 1'b0;
        end

        // read response
        if (rd_fire) begin
            r_next.rvalid = 1'b1;
            r_next.rresp  = RESP_OKAY;
            r_next.rdata  = 32'h0000_0000;
            case (s_axi_araddr)
                CFG_OFFSET:  r_next.rdata[CFG_W-1:0] = r_reg.cfg;
                DATA_OFFSET: r_next.rdata[CFG_W-1:0] = r_reg.data;
                STATUS_OFFSET: begin
                    r_next.rdata[ST_STANDBY_N]      = r_reg.standby_n;
                    r_next.rdata[ST_READY_N]        = r_reg.ready_n;
                    r_next.rdata[ST_SAMPLING]       = r_reg.sampling;
                    r_next.rdata[ST_SYNC_MODE]      = sync_mode;
                    r_next.rdata[ST_FSM_LSB +: 3]   = r_reg.state;
                end
                default:     r_next.rresp = RESP_SLVERR;
            endcase
        end else if (s_axi_rready) begin
            r_next.rvalid = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            r_reg.state     <= FSM_STANDBY;
            r_reg.cfg       <= CFG_RESET;
            r_reg.data      <= DATA_RESET;
            r_reg.cnt       <= CNT_ZERO;
            r_reg.ready_n   <= 1'b1;
            r_reg.standby_n <= 1'b0;
            r_reg.sampling  <= 1'b0;
            r_reg.sync_out  <= 1'b0;
            r_reg.sync_meta <= 1'b0;
            r_reg.sync_sync <= 1'b0;
            r_reg.sync_prev <= 1'b0;
            r_reg.bvalid    <= 1'b0;
            r_reg.bresp     <= RESP_OKAY;
            r_reg.rvalid    <= 1'b0;
            r_reg.rdata     <= 32'h0000_0000;
            r_reg.rresp     <= RESP_OKAY;
        end else begin
            r_reg <= r_next;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    logic [15:0] acq_len;
    logic [15:0] acq_goal;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            acq_len  <= CNT_ZERO;
            acq_goal <= CNT_ZERO;
        end else if (host_read && !wr_cfg) begin
            acq_len  <= CNT_ZERO;
            acq_goal <= acq_cycles(r_reg.cfg[ACQ_LSB +: 2]);
        end else if (r_reg.state == FSM_ACQ) begin
            acq_len  <= acq_len + CNT_ONE;
        end
    end

    a_standby_entry: assert property (wr_cfg && cmd_new == CMD_STANDBY |=> !standby_flag_n && ready_n)
        else $error("standby command did not lower standby flag");
    a_standby_exit: assert property (wr_cfg && cmd_new != CMD_STANDBY && r_reg.state == FSM_STANDBY
        |=> standby_flag_n && ready_n)
        else $error("standby flag not raised at exit request");
    a_ready_after_wake: assert property ((!standby_flag_n || r_reg.state == FSM_WAKE) |-> ready_n)
        else $error("ready low while still in standby");
    a_sync_drive: assert property (sync_oe |-> !sync_mode && (sync_out == (r_reg.state == FSM_CONV)))
        else $error("sync output disagrees with conversion");
    a_acq_length: assert property (r_reg.state == FSM_ACQ && r_next.state == FSM_CONV
        |-> acq_len + CNT_ONE == acq_goal)
        else $error("acquisition length wrong");
    a_read_arms: assert property (host_read && !wr_cfg && !sync_mode |=> ready_n && r_reg.state == FSM_ACQ)
        else $error("host read did not start acquisition");
    a_sync_paced: assert property ($rose(r_reg.state == FSM_CONV) && sync_mode |-> $past(sync_rise))
        else $error("synchronous conversion without sync edge");
    a_chan_sample: assert property (wr_cfg && chan_changed && cmd_new == CMD_START
        && r_reg.state == FSM_IDLE |=> sampling)
        else $error("channel change did not start sampling");
    a_ready_sample: assert property ($fell(ready_n) && !$past(wr_cfg) |-> sampling)
        else $error("ready fall did not start sampling");
    a_cal_run: assert property (wr_cfg && cmd_new == CMD_FULL_CAL && r_reg.state == FSM_IDLE
        |=> calibrating && ready_n)
        else $error("calibration not started");
    a_mux_single: assert property (r_reg.cfg[SINGLE_BIT] |-> mux_out_neg[COM_BIT])
        else $error("single-ended negative not on common reference");

    c_wake: cover property (r_reg.state == FSM_WAKE ##1 r_reg.state == FSM_IDLE);
    c_async_conv: cover property (r_reg.state == FSM_ACQ ##1 r_reg.state == FSM_CONV);
    c_sync_conv: cover property (r_reg.state == FSM_WAIT_SYNC ##1 r_reg.state == FSM_CONV);
    c_cal_done: cover property (r_reg.state == FSM_CAL ##1 r_reg.state == FSM_IDLE);

endmodule

/* File: tb/ams_host_model.sv */
`timescale 1ns/1ps
module ams_host_model (
    input  wire logic        clk_sys,
    input  wire logic        converting,
    input  wire logic        pulse,
    input  wire logic [12:0] value,
    output logic [12:0]      conv_result,
    output logic             sync_line
);
    int hi = 0;
    initial conv_result = 13'h0AAA;
    // result only valid while converting, else a moving pattern
    always @(posedge clk_sys) begin
        conv_result <= converting ? value : ~conv_result ^ 13'h1555;
        if (pulse) hi <= 4;
        else if (hi > 0) hi <= hi - 1;
    end
    assign sync_line = (hi > 0);
endmodule

/* File: tb/adc_mux_acquisition_sequencer_bench.sv */
`timescale 1ns/1ps
module adc_mux_acquisition_sequencer_bench
    import ams_pkg::*;
;
    logic clk_sys = 0, rst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0, pulse = 0;
    logic s_axi_bready = 1, s_axi_rready = 1, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, sync_out, sync_oe, sync_line, standby_flag_n, ready_n, sampling, converting, calibrating;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [12:0] conv_result, value = '0;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [7:0]  mux_out_pos;
    logic [8:0]  mux_out_neg;
    wire         sync_in = sync_oe ? sync_out : sync_line;
    int err_count = 0, checked = 0, cyc = 0, n, v, acq[4] = '{9, 15, 47, 79};
    int q[$];

    ams_core dut_u (.clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .conv_result, .sync_in, .sync_out, .sync_oe, .standby_flag_n, .ready_n,
        .sampling, .converting, .calibrating, .mux_out_pos, .mux_out_neg);
    ams_host_model host_u (.clk_sys, .converting, .pulse, .value, .conv_result, .sync_line);

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    always #2.5 clk_sys = ~clk_sys;
    // whole run is well under this, cal being the long part
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            end_sim();
        end
    end

    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] w);
        s_axi_awaddr <= a; s_axi_wdata <= w; s_axi_awvalid <= 1; s_axi_wvalid <= 1;
        do @(negedge clk_sys); while (s_axi_awready !== 1);
        @(posedge clk_sys); s_axi_awvalid <= 0; s_axi_wvalid <= 0;
        do @(negedge clk_sys); while (s_axi_bvalid !== 1);
        r = s_axi_bresp;
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [31:0] a);
        s_axi_araddr <= a; s_axi_arvalid <= 1;
        do @(negedge clk_sys); while (s_axi_arready !== 1);
        @(posedge clk_sys); s_axi_arvalid <= 0;
        do @(negedge clk_sys); while (s_axi_rvalid !== 1);
        d = s_axi_rdata; r = s_axi_rresp;
        @(posedge clk_sys);
    endtask

    task automatic wrdy();
        n = 0;
        do begin @(negedge clk_sys); n++; end while (ready_n !== 0);
        @(posedge clk_sys);
    endtask

    task end_sim();
        if (err_count == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'hEE746AE3));
        repeat (6) @(posedge clk_sys);
        rst_n <= 1;
        @(negedge clk_sys);
        chk("standby_flag_n", 0, standby_flag_n);
        chk("sync_oe", 0, sync_oe);
        @(posedge clk_sys);
        rd(CFG_OFFSET); chk("cfg", 32'h0100, d);
        rd(32'h10); chk("rresp", RESP_SLVERR, r);
        wr(32'h10, 32'h0801); chk("bresp", RESP_SLVERR, r);
        chk("standby_flag_n", 0, standby_flag_n);
        wr(CFG_OFFSET, 32'h0801); chk("standby_flag_n", 1, standby_flag_n);
        chk("bresp", RESP_OKAY, r);
        chk("ready_n", 1, ready_n);
        wrdy(); chk("sync_oe", 1, sync_oe);
        chk("sampling", 1, sampling);
        for (int c = 0; c < 16; c++) begin
            wr(CFG_OFFSET, 32'h0800 | c);
            chk("mux_out_pos", 1 << (c & 7), mux_out_pos);
            chk("mux_out_neg", c[3] ? 256 : 1 << ((c & 6) | (~c & 1)), mux_out_neg);
        end
        for (int a = 0; a < 4; a++) begin
            wr(CFG_OFFSET, 32'h0801 | (a << 4)); wrdy();
            v = $urandom & 32'h1FFF; value <= v[12:0]; q.push_back(v);
            rd(DATA_OFFSET); n = 0;
            do begin @(negedge clk_sys); n++; end while (sync_out !== 1 && n < 200);
            chk("acq cycles", acq[a], n);
            n = 0;
            do begin @(negedge clk_sys); n++; end while (sync_out !== 0 && n < 200);
            chk("conv cycles", CONV_CYC, n);
            chk("ready_n", 0, ready_n);
            @(posedge clk_sys);
            rd(DATA_OFFSET); chk("data", q.pop_front(), d);
        end
        wrdy();
        wr(CFG_OFFSET, 32'h0932); wrdy(); chk("sync_oe", 0, sync_oe);
        v = $urandom & 32'h1FFF; value <= v[12:0]; q.push_back(v);
        rd(DATA_OFFSET);
        repeat (100) @(negedge clk_sys);
        chk("converting", 0, converting);
        @(posedge clk_sys); pulse <= 1;
        @(posedge clk_sys); pulse <= 0; n = 0;
        do begin @(negedge clk_sys); n++; end while (converting !== 1 && n < 50);
        chk("sync latency", 1, n >= 2 && n <= 6);
        chk("sampling", 0, sampling);
        wrdy(); rd(DATA_OFFSET); chk("data", q.pop_front(), d);
        wr(CFG_OFFSET, 32'h0200); chk("calibrating", 1, calibrating);
        chk("ready_n", 1, ready_n);
        wrdy(); chk("cal length", CAL_CYC, n);
        wr(CFG_OFFSET, 32'h0000); chk("standby_flag_n", 0, standby_flag_n);
        rd(STATUS_OFFSET); chk("status", 0, d[ST_STANDBY_N]);
        end_sim();
    end
endmodule
